// ==== inc/llps_pkg.sv ====
`default_nettype none
package llps_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [15:0] STATUS_OFFSET  = 16'h0110;
  localparam logic [15:0] STATUS_RESET   = 16'h0004;
  localparam int          NUM_PORTS      = 4;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int          BIT_HOST_OPER  = 0;
  localparam int          BIT_WATCHDOG   = 1;
  localparam int          BIT_ENH_LINK   = 2;
  localparam int          BIT_RESERVED   = 3;
  localparam int          BIT_LINK_BASE  = 4;
  localparam int          BIT_LOOP_BASE  = 8;
  localparam int          BIT_COMM_BASE  = 9;
  localparam int          CFG_ENH_BIT    = 9;
  localparam int          CFG_ENH_HI     = 15;
  localparam int          CFG_ENH_LO     = 12;
  localparam int          EVT_STATUS_BIT = 2;
  localparam int          SYNC_STAGES    = 3;
endpackage
`default_nettype wire

// ==== rtl/llps_status.sv ====
`timescale 1ns/1ns
`default_nettype none
module llps_status (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cfgLoadDone,
  input  wire logic [15:0] cfgWord0,
  input  wire logic        hostPortReady,
  input  wire logic        watchdogReloaded,
  input  wire logic [3:0]  physLink,
  input  wire logic [3:0]  loopClosedReq,
  input  wire logic [3:0]  portFrameBusy,
  input  wire logic [3:0]  commStable,
  input  wire logic        netRead,
  input  wire logic        netWrite,
  input  wire logic [15:0] netAddr,
  input  wire logic        hostRead,
  input  wire logic        hostWrite,
  input  wire logic [15:0] hostAddr,
  output logic      [15:0] netRdData,
  output logic      [15:0] hostRdData,
  output logic             evtStatusClear,
  output logic      [15:0] linkLayerStatus
);
  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] linkS1, linkS2, linkS3, linkQ;
  logic [3:0] commS1, commS2, commS3, commQ;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      linkS1 <= 4'h0;
      linkS2 <= 4'h0;
      linkS3 <= 4'h0;
      commS1 <= 4'h0;
      commS2 <= 4'h0;
      commS3 <= 4'h0;
    end else begin
      linkS1 <= physLink;
      linkS2 <= linkS1;
      linkS3 <= linkS2;
      commS1 <= commStable;
      commS2 <= commS1;
      commS3 <= commS2;
    end
  end
  // A change counts once the second and third stages agree.
  wire [3:0] next_linkQ = (linkS2 & linkS3) | (linkQ & (linkS2 | linkS3));
  wire [3:0] next_commQ = (commS2 & commS3) | (commQ & (commS2 | commS3));

  // ------------------------------------------------------------------
  // Status sources
  // ------------------------------------------------------------------
  logic       cfgSeen;
  logic       enhLink;
  logic [3:0] loopClosed;
  wire        firstLoad  = cfgLoadDone && !cfgSeen;
  wire        cfgEnhOff  = !cfgWord0[llps_pkg::CFG_ENH_BIT] &&
                           (cfgWord0[llps_pkg::CFG_ENH_HI:llps_pkg::CFG_ENH_LO] == 4'h0);
  wire [3:0]  next_loop  = (loopClosedReq & ~portFrameBusy) | (loopClosed & portFrameBusy);
  wire        hostOper   = cfgLoadDone && hostPortReady;
  wire        netHit     = netAddr[15:1] == llps_pkg::STATUS_OFFSET[15:1];
  wire        hostHit    = hostAddr[15:1] == llps_pkg::STATUS_OFFSET[15:1];

  function automatic logic [7:0] pack_upper(input logic [3:0] loopV, input logic [3:0] commV);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < llps_pkg::NUM_PORTS; i++) begin
      r[2*i]   = loopV[i];
      r[2*i+1] = commV[i];
    end
    return r;
  endfunction

  wire [15:0] next_status = {pack_upper(loopClosed, commQ), linkQ,
                             1'b0, enhLink, watchdogReloaded, hostOper};

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      linkQ           <= 4'h0;
      commQ           <= 4'h0;
      cfgSeen         <= 1'b0;
      enhLink         <= 1'b1;
      loopClosed      <= 4'h0;
      linkLayerStatus <= llps_pkg::STATUS_RESET;
      netRdData       <= 16'h0000;
      hostRdData      <= 16'h0000;
      evtStatusClear  <= 1'b0;
    end else begin
      linkQ      <= next_linkQ;
      commQ      <= next_commQ;
      loopClosed <= next_loop;
      if (firstLoad) begin
        cfgSeen <= 1'b1;
        enhLink <= !cfgEnhOff;
      end
      // Writes are decoded nowhere, so they leave the register untouched.
      linkLayerStatus <= next_status;
      netRdData       <= (netRead && netHit) ? linkLayerStatus : 16'h0000;
      hostRdData      <= (hostRead && hostHit) ? linkLayerStatus : 16'h0000;
      evtStatusClear  <= netRead && netHit;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_read_clears_evt: assert property (@(posedge ref_clk) disable iff (!reset_n)
    netRead && netHit |=> evtStatusClear)
    else $error("Network read did not clear event bit.");
  a_no_spurious_clr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(netRead && netHit) |=> !evtStatusClear)
    else $error("Event clear without network read.");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !linkLayerStatus[llps_pkg::BIT_RESERVED])
    else $error("Reserved bit set.");
  a_host_oper_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(cfgLoadDone && hostPortReady) |=> !linkLayerStatus[llps_pkg::BIT_HOST_OPER])
    else $error("Operational bit set without load.");
  a_watchdog_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_WATCHDOG] == $past(watchdogReloaded))
    else $error("Watchdog bit mismatch.");
  a_enh_before_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfgSeen |-> enhLink)
    else $error("Enhanced link bit low before first load.");
  a_enh_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfgSeen && $past(cfgSeen) |-> $stable(enhLink))
    else $error("Enhanced link bit changed after first load.");
  a_enh_load_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
    firstLoad |=> enhLink == !$past(cfgEnhOff))
    else $error("Enhanced link bit wrong after first load.");
  a_loop_held_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    portFrameBusy[0] |=> loopClosed[0] == $past(loopClosed[0]))
    else $error("Loop changed during frame.");
  a_link_sync: assert property (@(posedge ref_clk) disable iff (!reset_n)
    physLink[3] [*6] |-> linkLayerStatus[llps_pkg::BIT_LINK_BASE+3])
    else $error("Link bit not reported.");
  c_net_read: cover property (@(posedge ref_clk) disable iff (!reset_n) netRead && netHit);
  c_first_load: cover property (@(posedge ref_clk) disable iff (!reset_n) firstLoad && cfgEnhOff);
  c_loop_delay: cover property (@(posedge ref_clk) disable iff (!reset_n)
    portFrameBusy[0] && loopClosedReq[0] != loopClosed[0]);
  c_net_write: cover property (@(posedge ref_clk) disable iff (!reset_n) netWrite && netHit);
  c_host_read: cover property (@(posedge ref_clk) disable iff (!reset_n) hostRead && hostHit);
  a_write_no_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (netWrite || hostWrite) && !netRead |=> !evtStatusClear)
    else $error("Write caused an event clear.");
  a_host_no_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hostRead && !netRead |=> !evtStatusClear)
    else $error("Host read caused an event clear.");
  a_net_rd_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
    netRead && netHit |=> netRdData == $past(linkLayerStatus))
    else $error("Network read data wrong.");
  a_net_rd_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(netRead && netHit) |=> netRdData == 16'h0000)
    else $error("Network read data without read.");
  a_host_rd_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hostRead && hostHit |=> hostRdData == $past(linkLayerStatus))
    else $error("Host read data wrong.");
  a_host_rd_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(hostRead && hostHit) |=> hostRdData == 16'h0000)
    else $error("Host read data without read.");
  a_enh_status_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_ENH_LINK] == $past(enhLink))
    else $error("Enhanced link status bit wrong.");
  a_host_oper_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfgLoadDone && hostPortReady |=> linkLayerStatus[llps_pkg::BIT_HOST_OPER])
    else $error("Operational bit not set.");
  a_link_field: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_LINK_BASE +: llps_pkg::NUM_PORTS] == $past(linkQ))
    else $error("Link field wrong.");
  a_loop_port0: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_LOOP_BASE] == $past(loopClosed[0]))
    else $error("Loop bit of port 0 wrong.");
  a_comm_port0: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_COMM_BASE] == $past(commQ[0]))
    else $error("Communication bit of port 0 wrong.");
  a_loop_port3: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_LOOP_BASE+6] == $past(loopClosed[3]))
    else $error("Loop bit of port 3 wrong.");
  a_comm_port3: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> linkLayerStatus[llps_pkg::BIT_COMM_BASE+6] == $past(commQ[3]))
    else $error("Communication bit of port 3 wrong.");
  a_loop_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !portFrameBusy[0] |=> loopClosed[0] == $past(loopClosedReq[0]))
    else $error("Loop setting not applied when idle.");
  a_loop3_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
    portFrameBusy[3] |=> loopClosed[3] == $past(loopClosed[3]))
    else $error("Loop of port 3 changed during frame.");
  a_link_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !physLink[3] [*6] |-> !linkLayerStatus[llps_pkg::BIT_LINK_BASE+3])
    else $error("Link bit stuck high.");
  a_comm_sync: assert property (@(posedge ref_clk) disable iff (!reset_n)
    commStable[3] [*6] |-> linkLayerStatus[llps_pkg::BIT_COMM_BASE+6])
    else $error("Communication bit not reported.");
  a_comm_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !commStable[3] [*6] |-> !linkLayerStatus[llps_pkg::BIT_COMM_BASE+6])
    else $error("Communication bit stuck high.");
  a_cfg_seen_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfgSeen |=> cfgSeen)
    else $error("First load marker lost.");
  a_first_load_marks: assert property (@(posedge ref_clk) disable iff (!reset_n)
    firstLoad |=> cfgSeen)
    else $error("First load not recorded.");
  a_reset_image: assert property (@(posedge ref_clk)
    !reset_n |=> linkLayerStatus == llps_pkg::STATUS_RESET)
    else $error("Status image wrong after reset.");
  a_reset_quiet: assert property (@(posedge ref_clk)
    !reset_n |=> !evtStatusClear && netRdData == 16'h0000 && hostRdData == 16'h0000)
    else $error("Read outputs active after reset.");
endmodule
`default_nettype wire

// ==== verif/llps_evt_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module llps_evt_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic evtSet,
  input  wire logic evtStatusClear,
  output logic      evtReq
);
  // Network event request bit that a network-side status read acknowledges.
  always_ff @(posedge ref_clk) begin
    if (!reset_n || evtStatusClear) evtReq <= 1'b0;
    else if (evtSet) evtReq <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== verif/link_layer_port_status_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module link_layer_port_status_tb;
  logic        ref_clk = 0, reset_n = 0, cfgLoadDone = 0, hostPortReady = 0;
  logic        watchdogReloaded = 0, netRead = 0, netWrite = 0, hostRead = 0;
  logic        hostWrite = 0, evtSet = 0, evtStatusClear, evtReq;
  logic [15:0] cfgWord0 = 16'h0000, netAddr = 16'h0000, hostAddr = 16'h0000;
  logic [15:0] netRdData, hostRdData, linkLayerStatus;
  logic [3:0]  physLink = 4'h0, loopClosedReq = 4'h0, portFrameBusy = 4'h0, commStable = 4'h0;
  int          err_total = 0, n_tests = 0;
  always #20 ref_clk = ~ref_clk;
  llps_status i_llps_status (.ref_clk, .reset_n, .cfgLoadDone, .cfgWord0, .hostPortReady,
    .watchdogReloaded, .physLink, .loopClosedReq, .portFrameBusy, .commStable, .netRead,
    .netWrite, .netAddr, .hostRead, .hostWrite, .hostAddr, .netRdData, .hostRdData,
    .evtStatusClear, .linkLayerStatus);
  llps_evt_model i_llps_evt_model (.ref_clk, .reset_n, .evtSet, .evtStatusClear, .evtReq);
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_load;
    {cfgLoadDone, hostPortReady, watchdogReloaded} = 3'b111;
    cyc(3);
    chk("status", 16'h0003, linkLayerStatus);
    cfgLoadDone = 0;
    cfgWord0 = 16'h1000;
    cyc(2);
    chk("status", 16'h0002, linkLayerStatus);
    cfgLoadDone = 1;
    watchdogReloaded = 0;
    cyc(3);
    chk("status", 16'h0001, linkLayerStatus);
  endtask
  task automatic t_second_reset;
    {reset_n, cfgLoadDone} = 2'b00;
    cyc(2);
    chk("status", 16'h0004, linkLayerStatus);
    {reset_n, cfgLoadDone} = 2'b11;
    cfgWord0 = 16'h0200;
    cyc(3);
    chk("status", 16'h0005, linkLayerStatus);
  endtask
  task automatic t_ports;
    {physLink, commStable, loopClosedReq} = 12'h88F;
    cyc(8);
    chk("status", 16'hD585, linkLayerStatus);
    {portFrameBusy, loopClosedReq} = 8'h1E;
    cyc(4);
    chk("status", 16'hD585, linkLayerStatus);
    portFrameBusy = 4'h0;
    cyc(3);
    chk("status", 16'hD485, linkLayerStatus);
  endtask
  task automatic t_reads;
    evtSet = 1;
    {netWrite, netAddr, hostWrite, hostAddr} = {1'b1, 16'h0110, 1'b1, 16'h0111};
    cyc(1);
    {evtSet, netWrite, hostWrite} = 3'b000;
    cyc(2);
    chk("status", 16'hD485, linkLayerStatus);
    chk("evtReq", 16'h0001, {15'h0000, evtReq});
    {netRead, netAddr} = {1'b1, 16'h0111};
    cyc(1);
    netRead = 0;
    chk("netRdData", 16'hD485, netRdData);
    chk("evtClear", 16'h0001, {15'h0000, evtStatusClear});
    {hostRead, hostAddr} = {1'b1, 16'h0110};
    cyc(1);
    hostRead = 0;
    chk("evtReq", 16'h0000, {15'h0000, evtReq});
    chk("hostRdData", 16'hD485, hostRdData);
    chk("evtClear", 16'h0000, {15'h0000, evtStatusClear});
    chk("netRdData", 16'h0000, netRdData);
  endtask
  initial begin
    cyc(6);
    chk("status", 16'h0004, linkLayerStatus);
    reset_n = 1;
    t_load();
    t_second_reset();
    t_ports();
    t_reads();
    report_and_stop();
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
